// ==== io_port_two.sv ====
`timescale 1ns/10ps
module io_port_two #(
  parameter int WIDTH = io_port_two_pkg::PORT_WIDTH
) (
  input  wire logic                                 i_clk,
  input  wire logic                                 i_rst,
  input  wire logic [WIDTH-1:0]                     i_dir_wdata,
  input  wire logic                                 i_dir_we,
  input  wire logic [WIDTH-1:0]                     i_od_wdata,
  input  wire logic                                 i_od_we,
  input  wire logic [WIDTH-1:0]                     i_data_wdata,
  input  wire logic                                 i_data_we,
  input  wire logic [WIDTH-1:0]                     i_alt_en_wdata,
  input  wire logic                                 i_alt_en_we,
  input  wire logic                                 i_thresh_wdata,
  input  wire logic                                 i_thresh_we,
  input  wire logic [WIDTH-1:0]                     i_capcom_channel_pin_out,
  input  wire logic [WIDTH-1:0]                     i_pin_in,
  output logic      [WIDTH-1:0]                     o_pin_out,
  output logic      [WIDTH-1:0]                     o_pin_oe,
  output logic      [WIDTH-1:0]                     o_port_rdata,
  output logic      [WIDTH-1:0]                     o_dir,
  output logic      [WIDTH-1:0]                     o_od,
  output logic                                      o_thresh_special,
  output logic      [WIDTH-1:0]                     o_capcom_channel_pin_in,
  output logic      [io_port_two_pkg::IRQ_COUNT-1:0] o_fast_ext_irq_input,
  output logic                                      o_timer_seven_count_input
);
  import io_port_two_pkg::*;

  // elaboration checks: the pin map is fixed at sixteen pins
  if (WIDTH != PORT_WIDTH) begin : g_bad_width
    $error("io_port_two needs WIDTH of 16");
  end
  if (WIDTH != CC_CHANNELS) begin : g_bad_cc
    $error("io_port_two needs one channel per pin");
  end
  if (IRQ_FIRST + IRQ_COUNT > WIDTH) begin : g_bad_irq
    $error("io_port_two irq pins beyond the port");
  end
  if (T7_PIN >= WIDTH) begin : g_bad_t7
    $error("io_port_two timer pin beyond the port");
  end

  logic [WIDTH-1:0] dir_reg;
  logic [WIDTH-1:0] od_reg;
  logic [WIDTH-1:0] data_reg;
  logic [WIDTH-1:0] alt_reg;
  logic             thresh_reg;
  logic [WIDTH-1:0] pin_sync_w;
  logic [WIDTH-1:0] drive_val;
  logic [WIDTH-1:0] drive_en;
  logic [WIDTH-1:0] drive_lvl;
  logic [WIDTH-1:0] read_val;

  // pin value: compare output when the alternate select is set
  function automatic logic pin_value(input logic alt, input logic cmp,
                                     input logic latch);
    pin_value = alt ? cmp : latch;
  endfunction

  // driver enable: off for inputs, low-only for open drain
  function automatic logic pin_enable(input logic dir, input logic od,
                                      input logic val);
    if (!dir) begin
      pin_enable = 1'b0;
    end else if (od) begin
      pin_enable = ~val;
    end else begin
      pin_enable = 1'b1;
    end
  endfunction

  // pad level: open drain pins never present a one
  function automatic logic pin_level(input logic od, input logic val);
    pin_level = val & ~od;
  endfunction

  // direction bits, 1 = output
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dir_reg <= DIR_RESET;
    end else if (i_dir_we) begin
      dir_reg <= i_dir_wdata;
    end
  end

  // open-drain select per pin
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      od_reg <= OD_RESET;
    end else if (i_od_we) begin
      od_reg <= i_od_wdata;
    end
  end

  // output latch
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      data_reg <= DATA_RESET;
    end else if (i_data_we) begin
      data_reg <= i_data_wdata;
    end
  end

  // per-pin alternate output select
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      alt_reg <= ALT_RESET;
    end else if (i_alt_en_we) begin
      alt_reg <= i_alt_en_wdata;
    end
  end

  // threshold select, passed to the pad
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      thresh_reg <= THRESH_RESET;
    end else if (i_thresh_we) begin
      thresh_reg <= i_thresh_wdata;
    end
  end

  // per-pin output value, driver enable and read value
  genvar p;
  generate
    for (p = 0; p < WIDTH; p++) begin : g_pin
      assign drive_val[p] = pin_value(alt_reg[p],
                                      i_capcom_channel_pin_out[p],
                                      data_reg[p]);
      assign drive_en[p]  = pin_enable(dir_reg[p], od_reg[p],
                                       drive_val[p]);
      assign drive_lvl[p] = pin_level(od_reg[p], drive_val[p]);
      // output pins read back the latch, inputs the synced pad
      assign read_val[p]  = dir_reg[p] ? data_reg[p] : pin_sync_w[p];
    end
  endgenerate

  // registered pad drive
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pin_out <= '0;
      o_pin_oe  <= '0;
    end else begin
      o_pin_out <= drive_lvl; // od drives low only
      o_pin_oe  <= drive_en;
    end
  end

  // registered configuration mirrors
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_dir <= DIR_RESET;
      o_od  <= OD_RESET;
    end else begin
      o_dir <= dir_reg;
      o_od  <= od_reg;
    end
  end

  // threshold select towards the pad
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_thresh_special <= THRESH_RESET;
    end else begin
      o_thresh_special <= thresh_reg;
    end
  end

  pin_sync #(
    .WIDTH (WIDTH)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (i_pin_in),
    .o_sync  (pin_sync_w)
  );

  // read path: latch for output pins, synchronised copy for inputs
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_port_rdata <= '0;
    end else begin
      o_port_rdata <= read_val;
    end
  end

  // capture inputs share the same synchronised copy
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_capcom_channel_pin_in <= '0;
    end else begin
      o_capcom_channel_pin_in <= pin_sync_w;
    end
  end

  // fast interrupt inputs from the upper pins
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_fast_ext_irq_input <= '0;
    end else begin
      o_fast_ext_irq_input <= pin_sync_w[IRQ_FIRST +: IRQ_COUNT];
    end
  end

  // timer seven count input from the top pin
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_timer_seven_count_input <= 1'b0;
    end else begin
      o_timer_seven_count_input <= pin_sync_w[T7_PIN];
    end
  end
endmodule

// ==== io_port_two_pkg.sv ====
package io_port_two_pkg;
  localparam int PORT_WIDTH   = 16;
  localparam int CC_CHANNELS  = 16;
  localparam int IRQ_FIRST    = 8;   // first pin feeding a fast irq input
  localparam int IRQ_COUNT    = 8;
  localparam int T7_PIN       = 15;  // pin feeding the timer seven count
  localparam logic [15:0] DIR_RESET   = 16'h0000; // all inputs after reset
  localparam logic [15:0] OD_RESET    = 16'h0000; // push-pull after reset
  localparam logic [15:0] DATA_RESET  = 16'h0000;
  localparam logic [15:0] ALT_RESET   = 16'h0000;
  localparam logic        THRESH_RESET = 1'b0;   // 0 standard, 1 special
endpackage

// ==== pin_sync.sv ====
`timescale 1ns/10ps
// three-stage synchroniser; change accepted when stages two and three agree
module pin_sync #(
  parameter int WIDTH = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  // synchroniser chain; meta_reg read only by s2_reg
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_reg <= '0;
      s2_reg   <= '0;
      s3_reg   <= '0;
    end else begin
      meta_reg <= i_async;
      s2_reg   <= meta_reg;
      s3_reg   <= s2_reg;
    end
  end

  // accept a bit only when stages two and three agree
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_acc
      logic acc_reg;
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          acc_reg <= 1'b0;
        end else if (s2_reg[g] == s3_reg[g]) begin
          acc_reg <= s3_reg[g];
        end
      end
      assign o_sync[g] = acc_reg;
    end
  endgenerate
endmodule

// ==== io_port_two_props.sv ====
`timescale 1ns/10ps
module io_port_two_props
  import io_port_two_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic                 i_clk,
  input wire logic                 i_rst,
  input wire logic [WIDTH-1:0]     i_dir_wdata,
  input wire logic                 i_dir_we,
  input wire logic                 i_thresh_wdata,
  input wire logic                 i_thresh_we,
  input wire logic [WIDTH-1:0]     i_pin_in,
  input wire logic [WIDTH-1:0]     o_pin_out,
  input wire logic [WIDTH-1:0]     o_pin_oe,
  input wire logic [WIDTH-1:0]     o_port_rdata,
  input wire logic [WIDTH-1:0]     o_dir,
  input wire logic [WIDTH-1:0]     o_od,
  input wire logic                 o_thresh_special,
  input wire logic [WIDTH-1:0]     o_capcom_channel_pin_in,
  input wire logic [IRQ_COUNT-1:0] o_fast_ext_irq_input,
  input wire logic                 o_timer_seven_count_input
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // pad enables follow direction and driver kind
  a_input_hi_z: assert property ((o_pin_oe & ~o_dir) == 0)
    else $error("input pin driving");
  a_od_no_high: assert property ((o_pin_out & o_od) == 0)
    else $error("open drain pin high");
  // alternate inputs share the synced pins
  a_irq_map: assert property (
    o_fast_ext_irq_input == o_capcom_channel_pin_in[15:8])
    else $error("irq input map");
  a_t7_map: assert property (
    o_timer_seven_count_input == o_capcom_channel_pin_in[15])
    else $error("timer input map");
  a_rd_inputs: assert property (
    !i_dir_we && !$past(i_dir_we) && !$past(i_dir_we, 2)
    |-> ((o_port_rdata ^ o_capcom_channel_pin_in) & ~o_dir) == 0)
    else $error("read of input pins");
  // config writes land two edges later
  a_dir_write: assert property (
    i_dir_we |-> ##2 o_dir == $past(i_dir_wdata, 2))
    else $error("direction write");
  a_thresh_write: assert property (
    i_thresh_we |-> ##2 o_thresh_special == $past(i_thresh_wdata, 2))
    else $error("threshold write");
  a_sync_pins: assert property (
    $stable(i_pin_in)[*8] |-> o_capcom_channel_pin_in == i_pin_in)
    else $error("synced pins stale");
endmodule
bind io_port_two io_port_two_props #(.WIDTH(WIDTH)) u_io_port_two_props (
  .i_clk, .i_rst, .i_dir_wdata, .i_dir_we, .i_thresh_wdata, .i_thresh_we,
  .i_pin_in, .o_pin_out, .o_pin_oe, .o_port_rdata, .o_dir, .o_od,
  .o_thresh_special, .o_capcom_channel_pin_in, .o_fast_ext_irq_input,
  .o_timer_seven_count_input);

// ==== board_model.sv ====
`timescale 1ns/10ps
module board_model (
  input  wire logic [15:0] i_pin_out,
  input  wire logic [15:0] i_pin_oe,
  input  wire logic [15:0] i_ext,
  input  wire logic [15:0] i_ext_en,
  output logic      [15:0] o_pad
);
  // pad level: port driver, else board driver, else pull-up
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      o_pad[i] = i_pin_oe[i] ? i_pin_out[i]
                             : (i_ext_en[i] ? i_ext[i] : 1'b1);
    end
  end
endmodule

// ==== tb.sv ====
`timescale 1ns/10ps
module tb;
  import io_port_two_pkg::*;
  logic        clk = 0, rst = 1, dwe = 0, owe = 0, awe = 0, xwe = 0;
  logic        twe = 0, tw = 0, t7, th;
  logic [15:0] dw = 0, ext = 0, ext_en = 0, pad, pout, poe, rd, dir, od, cc;
  logic [15:0] cco = 16'h1234;
  logic [7:0]  irq;
  int          n_fail = 0, samples_checked = 0;
  io_port_two u_io_port_two (.i_clk(clk), .i_rst(rst), .i_dir_wdata(dw),
    .i_dir_we(dwe), .i_od_wdata(dw), .i_od_we(owe), .i_data_wdata(dw),
    .i_data_we(awe), .i_alt_en_wdata(dw), .i_alt_en_we(xwe),
    .i_thresh_wdata(tw), .i_thresh_we(twe),
    .i_capcom_channel_pin_out(cco), .i_pin_in(pad), .o_pin_out(pout),
    .o_pin_oe(poe), .o_port_rdata(rd), .o_dir(dir), .o_od(od),
    .o_thresh_special(th), .o_capcom_channel_pin_in(cc),
    .o_fast_ext_irq_input(irq), .o_timer_seven_count_input(t7));
  board_model u_board_model (.i_pin_out(pout), .i_pin_oe(poe), .i_ext(ext),
    .i_ext_en(ext_en), .o_pad(pad));
  always #4 clk = ~clk;
  // one pulse write: 0 dir, 1 od, 2 data, 3 alt, other threshold
  task wr(input int s, input logic [15:0] v);
    dw = v;
    tw = v[0];
    case (s)
      0: dwe = 1;
      1: owe = 1;
      2: awe = 1;
      3: xwe = 1;
      default: twe = 1;
    endcase
    wt(1);
    {dwe, owe, awe, xwe, twe} = 0;
    wt(1); // idle edge so the next call never re-drives a strobe
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input string n, input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard
  initial begin
    #20000;
    n_fail++;
    complete_run;
  end
  initial begin
    wt(20);
    rst = 0;
    chk("oe", poe, 16'h0000);
    ext = 16'hA5C3;
    ext_en = 16'hFFFF;
    wt(8);
    chk("rd", rd, 16'hA5C3);
    chk("cc", cc, 16'hA5C3);
    chk("irq", {8'h00, irq}, 16'h00A5);
    chk("t7", {15'h0, t7}, 16'h0001);
    wr(2, 16'h00FF);
    wr(0, 16'h0F0F);
    ext_en = 16'hF0F0;
    wt(8);
    chk("oe", poe, 16'h0F0F);
    chk("out", pout & poe, 16'h000F);
    chk("rd", rd, 16'hA0CF);
    wr(1, 16'hFFFF);
    wr(3, 16'h0000);
    wr(4, 16'h0001);
    wt(3);
    chk("od oe", poe, 16'h0F00);
    chk("od out", pout, 16'h0000);
    chk("th", {15'h0, th}, 16'h0001);
    chk("dir", dir, 16'h0F0F);
    chk("od", od, 16'hFFFF);
    wr(1, 16'h0000);
    wr(3, 16'hFFFF);
    wt(3);
    chk("alt out", pout, 16'h1234);
    chk("alt oe", poe, 16'h0F0F);
    rst = 1;
    wt(2);
    rst = 0;
    chk("rst oe", poe, 16'h0000);
    chk("rst dir", dir, 16'h0000);
    ext = 16'h5A00;
    ext_en = 16'hFFFF;
    wt(8);
    chk("cc2", cc, 16'h5A00);
    chk("irq2", {8'h00, irq}, 16'h005A);
    chk("t72", {15'h0, t7}, 16'h0000);
    complete_run;
  end
endmodule
